// *** hw/pvc_top.sv ***
// pin volume converter control: register pair, pacing, hysteresis, gain
// assumes a byte register port and an analog comparator on the volume pin
//
// Contract
// R1: top control bit picks volume source; register mode powers down
// R2: one bit picks the converter clock source
// R3: clock bit zero oscillator, one master clock
// R4: hysteresis code 01 one code, 10 two
// R5: software writes reserved bit 3 only zero
// R6: throughput code doubles rate, 15.625 Hz base
// R7: oscillator source scales rates from its frequency
// R8: read-only 7-bit gain, all-ones code reserved
module pvc_top #(
    parameter longint CONV_DIV_BASE = pvc_pkg::DIV_BASE
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        pin_gain_sense_input,
    input  wire logic        osc_in,
    output logic             vol_from_pin,
    output logic             sar_power_down,
    output logic [6:0]       sar_trial_code,
    output logic [6:0]       pin_gain
);
    import pvc_pkg::*;

    pvc_sar_if sif ();

    logic [7:0]        ctrl_q;
    logic              gain_rsv_q;
    logic [7:0]        rdata_q;
    logic              pd_q;
    logic [2:0]        cmp_s_q;
    logic              cmp_f_q;
    logic [2:0]        osc_s_q;
    logic              osc_f_q;
    logic              osc_rise;
    logic              src_tick;
    logic [RATE_W-1:0] rate_cnt_q;
    logic [RATE_W-1:0] period;
    logic              start_q;
    logic [6:0]        gain_q;
    logic              valid_q;
    logic [6:0]        diff;
    logic [6:0]        hyst_lim;
    logic [1:0]        hyst;

    pvc_sar u_sar (
        .mclk (mclk),
        .rst  (rst),
        .sif  (sif)
    );

    // register port; bit 3 is stored as written, software keeps it zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q     <= CTRL_RESET;
            gain_rsv_q <= GAIN_RSV_RESET;
        end else if (reg_wr) begin
            if (reg_addr == CTRL_ADDR)
                ctrl_q <= reg_wdata; // R5
            if (reg_addr == GAIN_ADDR)
                gain_rsv_q <= reg_wdata[GAIN_RSV_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= RDATA_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                CTRL_ADDR: rdata_q <= ctrl_q;
                GAIN_ADDR: rdata_q <= {gain_rsv_q, gain_q}; // R8
                default:   rdata_q <= RDATA_RESET;
            endcase
        end
    end

    // register mode holds the converter powered down
    always_ff @(posedge mclk) begin
        if (rst) begin
            pd_q <= 1'b1;
        end else begin
            pd_q <= !ctrl_q[CTRL_SRC_BIT]; // R1
        end
    end

    // pins are asynchronous; accept a level once stages two and three agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmp_s_q <= 3'h0;
            cmp_f_q <= 1'b0;
            osc_s_q <= 3'h0;
            osc_f_q <= 1'b0;
        end else begin
            cmp_s_q <= {cmp_s_q[1:0], pin_gain_sense_input};
            osc_s_q <= {osc_s_q[1:0], osc_in};
            if (cmp_s_q[1] == cmp_s_q[2])
                cmp_f_q <= cmp_s_q[2];
            if (osc_s_q[1] == osc_s_q[2])
                osc_f_q <= osc_s_q[2];
        end
    end

    assign osc_rise = (osc_s_q[1] == osc_s_q[2]) && osc_s_q[2] && !osc_f_q;
    // oscillator rate limited by sync: needs osc well below mclk / 4
    assign src_tick = !pd_q && (ctrl_q[CTRL_CLK_BIT] || osc_rise); // R2 R3 R7

    // each throughput step halves the tick count per conversion
    assign period = RATE_W'(CONV_DIV_BASE >> ctrl_q[CTRL_THR_HI:CTRL_THR_LO]);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_cnt_q <= RATE_ZERO;
            start_q    <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (pd_q) begin
                rate_cnt_q <= RATE_ZERO; // R1
            end else if (src_tick) begin
                if (rate_cnt_q >= period - RATE_ONE) begin
                    rate_cnt_q <= RATE_ZERO; // R6
                    start_q    <= 1'b1;
                end else begin
                    rate_cnt_q <= rate_cnt_q + RATE_ONE;
                end
            end
        end
    end

    assign sif.start   = start_q;
    assign sif.abort   = pd_q;
    assign sif.step_en = src_tick;
    assign sif.cmp     = cmp_f_q;

    // hysteresis against the gain now shown; code 11 behaves as 00
    assign hyst = ctrl_q[CTRL_HYST_HI:CTRL_HYST_LO];
    assign diff = (sif.result > gain_q) ? sif.result - gain_q
                                        : gain_q - sif.result;
    assign hyst_lim = (hyst == HYST_1) ? HYST_ONE :
                      (hyst == HYST_2) ? HYST_TWO : SAR_ZERO; // R4

    always_ff @(posedge mclk) begin
        if (rst) begin
            gain_q  <= GAIN_RESET;
            valid_q <= 1'b0;
        end else if (pd_q) begin
            valid_q <= 1'b0;
        end else if (sif.done && (!valid_q || diff > hyst_lim)) begin
            valid_q <= 1'b1;
            if (sif.result == GAIN_RSV_CODE)
                gain_q <= GAIN_MAX_CODE; // R8
            else
                gain_q <= sif.result; // R4
        end
    end

    assign reg_rdata      = rdata_q;
    assign vol_from_pin   = ctrl_q[CTRL_SRC_BIT];
    assign sar_power_down = pd_q;
    assign sar_trial_code = sif.trial;
    assign pin_gain       = gain_q;

    AST_REG_MODE_IDLE: assert property (@(posedge mclk) disable iff (rst) // R1
        pd_q |=> !sif.busy && rate_cnt_q == RATE_ZERO)
        else $error("converter active in register volume mode");

    AST_CLK_SELECT: assert property (@(posedge mclk) disable iff (rst) // R2
        !pd_q && !ctrl_q[CTRL_CLK_BIT] && !osc_rise && sif.busy
        |=> sif.busy && $stable(sif.trial))
        else $error("converter stepped without selected clock");

    AST_MCLK_PACE: assert property (@(posedge mclk) disable iff (rst) // R3
        !pd_q && ctrl_q[CTRL_CLK_BIT] && rate_cnt_q < period - RATE_ONE
        |=> rate_cnt_q == $past(rate_cnt_q) + RATE_ONE)
        else $error("rate counter missed a master clock tick");

    AST_OSC_PACE: assert property (@(posedge mclk) disable iff (rst) // R7
        !pd_q && !ctrl_q[CTRL_CLK_BIT] && !osc_rise |=> $stable(rate_cnt_q))
        else $error("rate counter moved without oscillator edge");

    AST_RATE_WRAP: assert property (@(posedge mclk) disable iff (rst) // R6
        src_tick && rate_cnt_q == period - RATE_ONE
        |=> start_q && rate_cnt_q == RATE_ZERO)
        else $error("conversion not started at end of period");

    AST_HYST_HOLD: assert property (@(posedge mclk) disable iff (rst) // R4
        !pd_q && sif.done && valid_q && diff <= hyst_lim |=> $stable(gain_q))
        else $error("gain moved inside hysteresis band");

    AST_HYST_TWO: assert property (@(posedge mclk) disable iff (rst) // R4
        !pd_q && sif.done && valid_q && hyst == HYST_2 && diff == 7'h03
        && sif.result != GAIN_RSV_CODE
        |=> gain_q == $past(sif.result))
        else $error("gain not taken beyond two code band");

    AST_GAIN_RSV: assert property (@(posedge mclk) disable iff (rst) // R8
        gain_q != GAIN_RSV_CODE)
        else $error("reserved gain code reported");
endmodule // pvc_top

// *** hw/pvc_pkg.sv ***
// constants and types for the pin volume converter control block
// assumes a single 125 MHz mclk domain and a byte-wide register port
package pvc_pkg;
    localparam logic [7:0] CTRL_ADDR      = 8'h74;
    localparam logic [7:0] GAIN_ADDR      = 8'h75;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic       GAIN_RSV_RESET = 1'h0;
    localparam logic [7:0] RDATA_RESET    = 8'h00;

    // control and gain register fields
    localparam int CTRL_SRC_BIT = 7;
    localparam int CTRL_CLK_BIT = 6;
    localparam int CTRL_HYST_HI = 5;
    localparam int CTRL_HYST_LO = 4;
    localparam int CTRL_THR_HI  = 2;
    localparam int CTRL_THR_LO  = 0;
    localparam int GAIN_RSV_BIT = 7;

    localparam logic [1:0] HYST_1 = 2'h1;
    localparam logic [1:0] HYST_2 = 2'h2;

    localparam int         SAR_W         = 7;
    localparam logic [6:0] SAR_MSB_TRIAL = 7'h40;
    localparam logic [6:0] SAR_ZERO      = 7'h00;
    localparam logic [2:0] SAR_TOP_IDX   = 3'h6;
    localparam logic [2:0] SAR_LAST_IDX  = 3'h0;
    localparam logic [6:0] GAIN_RSV_CODE = 7'h7f;
    localparam logic [6:0] GAIN_MAX_CODE = 7'h7e;
    localparam logic [6:0] GAIN_RESET    = 7'h00;
    localparam logic [6:0] HYST_ONE      = 7'h01;
    localparam logic [6:0] HYST_TWO      = 7'h02;

    // conversion pacing: source ticks per conversion at throughput code 0
    localparam int         RATE_W        = 20;
    localparam logic [19:0] RATE_ZERO    = 20'h00000;
    localparam logic [19:0] RATE_ONE     = 20'h00001;
    localparam longint     REF_CLK_HZ    = 12_000_000;
    localparam longint     RATE0_MILLIHZ = 15_625;
    localparam longint     DIV_BASE      = REF_CLK_HZ * 64'd1000 / RATE0_MILLIHZ;

    // comparator settling before each trial is judged
    localparam int          MCLK_PERIOD_NS = 8;
    localparam int          SAR_SETTLE_NS  = 32;
    localparam int          SETTLE_CYC_I   =
        (SAR_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [3:0]  SETTLE_CYC     = 4'(SETTLE_CYC_I);
    localparam logic [3:0]  SETTLE_ZERO    = 4'h0;

    typedef enum logic {SAR_IDLE, SAR_CONV} pvc_sar_st_t;
endpackage : pvc_pkg

// *** hw/pvc_sar_if.sv ***
// signals between the converter control and the successive approximation
// engine; both ends run on mclk
interface pvc_sar_if;
    logic       start;
    logic       abort;
    logic       step_en;
    logic       cmp;
    logic       busy;
    logic       done;
    logic [6:0] trial;
    logic [6:0] result;
    modport ctl (output start, abort, step_en, cmp,
                 input  busy, done, trial, result);
    modport sar (input  start, abort, step_en, cmp,
                 output busy, done, trial, result);
endinterface : pvc_sar_if

// *** hw/pvc_sar.sv ***
// 7-bit successive approximation engine, each trial steps on the first source tick after settling
// assumes cmp is already synchronised and high when pin >= trial level
module pvc_sar (
    input wire logic    mclk,
    input wire logic    rst,
    pvc_sar_if.sar      sif
);
    import pvc_pkg::*;

    pvc_sar_st_t st_q;
    logic [2:0]  idx_q;
    logic [6:0]  trial_q;
    logic [6:0]  result_q;
    logic [3:0]  settle_q;
    logic        done_q;
    logic [6:0]  kept;

    always_comb begin
        kept = trial_q;
        kept[idx_q] = sif.cmp;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q     <= SAR_IDLE;
            idx_q    <= SAR_LAST_IDX;
            trial_q  <= SAR_ZERO;
            result_q <= SAR_ZERO;
            settle_q <= SETTLE_ZERO;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                SAR_IDLE: begin
                    if (sif.start && !sif.abort) begin
                        trial_q  <= SAR_MSB_TRIAL;
                        idx_q    <= SAR_TOP_IDX;
                        settle_q <= SETTLE_ZERO;
                        st_q     <= SAR_CONV;
                    end
                end
                SAR_CONV: begin
                    if (sif.abort) begin
                        st_q    <= SAR_IDLE;
                        trial_q <= SAR_ZERO;
                    end else if (settle_q != SETTLE_CYC) begin
                        settle_q <= settle_q + 4'h1;
                    end else if (sif.step_en) begin
                        settle_q <= SETTLE_ZERO;
                        if (idx_q == SAR_LAST_IDX) begin
                            result_q <= kept;
                            trial_q  <= kept;
                            done_q   <= 1'b1;
                            st_q     <= SAR_IDLE;
                        end else begin
                            trial_q            <= kept;
                            trial_q[idx_q - 3'h1] <= 1'b1;
                            idx_q              <= idx_q - 3'h1;
                        end
                    end
                end
                default: st_q <= SAR_IDLE;
            endcase
        end
    end

    assign sif.busy   = (st_q == SAR_CONV);
    assign sif.done   = done_q;
    assign sif.trial  = trial_q;
    assign sif.result = result_q;
endmodule // pvc_sar

// *** test/pvc_pin_model.sv ***
// comparator model standing at the volume pin
// assumes an ideal ladder driven by the design's trial code
module pvc_pin_model (
    input  wire logic       clk,
    input  wire logic [6:0] trial,
    input  wire logic       power_down,
    input  wire logic [6:0] level,
    output logic            cmp = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // powered down: no valid answer, so the line wanders each cycle
    always @(negedge clk or trial or level or power_down) begin
        cmp = power_down ? ~cmp : (level >= trial);
    end
endmodule // pvc_pin_model

// *** test/tb_top.sv ***
// self-checking bench for the pin volume converter control
// assumes a shortened pacing base and the ideal pin comparator model
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pvc_pkg::*;
    localparam int BASE = 16384;
    logic        mclk           = 1'b0;
    logic        rst            = 1'b1;
    logic [7:0]  reg_addr       = 8'h00;
    logic        reg_wr         = 1'b0;
    logic        reg_rd         = 1'b0;
    logic [7:0]  reg_wdata      = 8'h00;
    logic [7:0]  reg_rdata;
    logic        sense;
    logic        osc_in         = 1'b0;
    logic        osc_run        = 1'b0;
    logic [2:0]  osc_cnt        = 3'h0;
    logic        vol_from_pin;
    logic        sar_power_down;
    logic [6:0]  sar_trial_code;
    logic [6:0]  pin_gain;
    logic [6:0]  level          = 7'h00;
    logic [6:0]  g;
    logic [7:0]  rd_v;
    logic [31:0] seed           = 32'h5b32;
    int          miscompares    = 0;
    int          checks_done    = 0;
    int          iv;

    pvc_top #(.CONV_DIV_BASE(BASE)) dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pin_gain_sense_input(sense), .osc_in(osc_in),
        .vol_from_pin(vol_from_pin), .sar_power_down(sar_power_down),
        .sar_trial_code(sar_trial_code), .pin_gain(pin_gain));
    pvc_pin_model pin (.clk(mclk), .trial(sar_trial_code),
        .power_down(sar_power_down), .level(level), .cmp(sense));

    initial begin
        forever #4 mclk = ~mclk;
    end
    // oscillator of 16 mclk periods, slow enough for the filter
    always @(negedge mclk) begin
        osc_cnt <= osc_cnt + 3'h1;
        if (osc_run && osc_cnt == 3'h7) osc_in <= ~osc_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [6:0] conv_exp(input logic [6:0] lv);
        return (lv == 7'h7f) ? 7'h7e : lv;
    endfunction

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic wait_gain(input logic [6:0] e);
        for (int i = 0; i < 3000 && pin_gain !== e; i++) @(negedge mclk);
        chk("pin_gain", {1'b0, pin_gain}, {1'b0, e});
    endtask
    // zero level: each start shows as trial 0x00 -> 0x40
    task automatic measure(output int n);
        int s[3];
        int k;
        int t;
        logic [6:0] prev;
        k = 0;
        t = 0;
        prev = sar_trial_code;
        while (k < 3 && t < 7000) begin
            @(negedge mclk);
            t++;
            if (sar_trial_code === SAR_MSB_TRIAL && prev === SAR_ZERO) begin
                s[k] = t;
                k++;
            end
            prev = sar_trial_code;
        end
        n = (k == 3) ? s[2] - s[1] : 0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        chk("power_down", {7'h0, sar_power_down}, 8'h01);
        chk("vol_from_pin", {7'h0, vol_from_pin}, 8'h00);
        rd(CTRL_ADDR, rd_v);
        chk("ctrl", rd_v, CTRL_RESET);
        rd(8'h76, rd_v);
        chk("unmapped", rd_v, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(CTRL_ADDR, seed[7:0] & 8'hf7);
            @(negedge mclk);
            chk("vol_from_pin", {7'h0, vol_from_pin}, {7'h0, seed[7]});
            chk("power_down", {7'h0, sar_power_down}, {7'h0, ~seed[7]});
            rd(CTRL_ADDR, rd_v);
            chk("ctrl", rd_v, seed[7:0] & 8'hf7);
        end
        wr(8'h73, 8'h55);
        rd(CTRL_ADDR, rd_v);
        chk("ctrl", rd_v, seed[7:0] & 8'hf7);
        $display("test control done");
        wr(CTRL_ADDR, 8'hf7);
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            level = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : seed[6:0];
            wait_gain(conv_exp(level));
            rd(GAIN_ADDR, rd_v);
            chk("gain reg", rd_v, {1'b0, conv_exp(level)});
        end
        wr(GAIN_ADDR, 8'h2a);
        rd(GAIN_ADDR, rd_v);
        chk("gain read only", rd_v, {1'b0, conv_exp(level)});
        $display("test conversion done");
        g = 7'h20 + {2'h0, seed[4:0]};
        level = g;
        wait_gain(g);
        wr(CTRL_ADDR, 8'hd7);
        level = g + 7'h1;
        repeat (400) @(negedge mclk);
        chk("hyst one hold", {1'b0, pin_gain}, {1'b0, g});
        level = g + 7'h2;
        wait_gain(g + 7'h2);
        wr(CTRL_ADDR, 8'he7);
        level = g + 7'h4;
        repeat (400) @(negedge mclk);
        chk("hyst two hold", {1'b0, pin_gain}, {1'b0, g + 7'h2});
        level = g + 7'h5;
        wait_gain(g + 7'h5);
        $display("test hysteresis done");
        level = 7'h00;
        for (int t = 7; t >= 4; t--) begin
            wr(CTRL_ADDR, 8'hf0 | 8'(t));
            measure(iv);
            chk("mclk period", {7'h0, iv == (BASE >> t)}, 8'h01);
        end
        $display("test rate done");
        // oscillator source with the oscillator stopped: no conversions
        wr(CTRL_ADDR, 8'hb7);
        measure(iv);
        chk("osc stopped", {7'h0, iv == 0}, 8'h01);
        osc_run = 1'b1;
        measure(iv);
        chk("osc period", {7'h0, iv == (BASE >> 7) * 16}, 8'h01);
        $display("test oscillator done");
        tally_and_finish();
    end
endmodule // tb_top
